// *** rtl/phyx_defines.svh ***
// phyx_defines.svh: offsets, field positions, reset values and timing counts
// for the expansion and vendor configuration registers.
// assumes: included by bare name from rtl files; definitions only.
`ifndef PHYX_DEFINES_SVH
`define PHYX_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define PHYX_IDX_EXPANSION   8'h06
`define PHYX_IDX_VENDOR_CFG  8'h10
`define PHYX_ADDR_EXPANSION  12'h018
`define PHYX_ADDR_VENDOR_CFG 12'h040

// expansion register bit positions
`define PHYX_EXP_PARTNER_AN   0
`define PHYX_EXP_PAGE_RX      1
`define PHYX_EXP_LOCAL_NP     2
`define PHYX_EXP_PARTNER_NP   3
`define PHYX_EXP_PD_FAULT     4

// vendor configuration bit positions
`define PHYX_CFG_LOOP_OUT     0
`define PHYX_CFG_SLEEP        1
`define PHYX_CFG_PREAMBLE     2
`define PHYX_CFG_SM_RESET     3
`define PHYX_CFG_RPD_EN       4
`define PHYX_CFG_FORCE_100    7
`define PHYX_CFG_RSVD_HI_LSB  10
`define PHYX_CFG_RSVD_MID_LSB 5

// writable mask and reset value of the vendor configuration register
`define PHYX_CFG_WMASK        16'hFCFF
`define PHYX_CFG_RESET        16'h0410

// state machine reset pulse length
`define PHYX_STATE_MACHINE_RESET_NS         200
`define PHYX_CLK_NS           50
`define PHYX_STATE_MACHINE_RESET_CYCLES     ((`PHYX_STATE_MACHINE_RESET_NS + `PHYX_CLK_NS - 1) / `PHYX_CLK_NS)

`define PHYX_ZERO16           16'h0000
`define PHYX_ZERO32           32'h0000_0000
`define PHYX_HTRANS_NONSEQ_BIT 1
`define PHYX_HSIZE_WORD       3'h2

`endif

// *** rtl/phyx_pkg.sv ***
// phyx_pkg.sv: types shared by the register bank and its reset sequencer.
// assumes: compiled before every other rtl file.
package phyx_pkg;

  // status arriving from the negotiation engine and line logic
  typedef struct packed {
    logic pd_fault_evt;      // one-cycle pulse
    logic page_rx_evt;       // one-cycle pulse
    logic partner_local_next_page_able;   // level
    logic partner_an_able;   // level
    logic link_100_raw;      // level
  } phyx_status_t;

  // controls driven to the rest of the PHY
  typedef struct packed {
    logic link_100_good;
    logic auto_reduced_power_en;
    logic mgmt_preamble_suppress;
    logic sleep_mode;
    logic remote_loop_out;
    logic state_machine_reset;
  } phyx_ctrl_t;

  typedef enum logic [1:0] {
    PHYX_RST_IDLE,
    PHYX_RST_BUSY
  } phyx_rst_state_t;

endpackage

// *** rtl/phyx_state_machine_reset_seq.sv ***
// phyx_state_machine_reset_seq.sv: stretches a state machine reset request into a
// fixed-length pulse and reports completion.
// assumes: same clock as the register bank; start is a one-cycle pulse.
`timescale 1ns/1ns
`include "phyx_defines.svh"

module phyx_state_machine_reset_seq
  import phyx_pkg::*;
#(
  parameter int unsigned CYCLES = `PHYX_STATE_MACHINE_RESET_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  // request and status
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int unsigned CW = (CYCLES < 2) ? 1 : $clog2(CYCLES);

  // elaboration check: with CYCLES at zero the loaded count would wrap to one, not give a zero-length pulse
  if (CYCLES < 1) begin : g_bad_cycles
    $error("phyx_state_machine_reset_seq: CYCLES must be at least 1");
  end

  phyx_rst_state_t state;
  logic [CW-1:0]   count;

  // counts the pulse; a fresh start while busy restarts the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PHYX_RST_IDLE;
      count <= '0;
      done  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      unique case (state)
        PHYX_RST_IDLE: begin
          if (start) begin
            state <= PHYX_RST_BUSY;
            count <= CW'(CYCLES - 1);
          end
        end
        PHYX_RST_BUSY: begin
          if (start) begin
            count <= CW'(CYCLES - 1);
          end else if (count == '0) begin
            state <= PHYX_RST_IDLE;
            done  <= 1'b1;
          end else begin
            count <= count - 1'b1;
          end
        end
        default: state <= PHYX_RST_IDLE;
      endcase
    end
  end

  assign busy = (state == PHYX_RST_BUSY);

endmodule

// *** rtl/phyx_regs.sv ***
// phyx_regs.sv: auto-negotiation expansion and vendor configuration registers
// of a fast ethernet PHY, reached over an AHB-Lite slave port.
// assumes: one clock hclk at 20 MHz; status inputs come from the PHY core on
// the same clock; this is the only slave so hreadyout is the bus hready.
`timescale 1ns/1ns
`include "phyx_defines.svh"

// Operation
// - parallel detection fault latches high until management reads the register.
// - read-only bit shows whether the partner offers a next page.
// - local next-page ability always reads zero.
// - page-received latches on a new page and clears on expansion read.
// - partner auto-negotiation ability bit follows partner support.
// - expansion reserved upper bits read zero; writes to them are ignored.
// - force-100 bit reports good 100 Mbps link regardless of line.
// - reduced-power-down enable resets to one and gates automatic power down.
// - writing one to state machine reset pulses reset, then self-clears.
// - preamble suppression bit resets to zero and drives suppression control.
// - writing one to sleep puts the PHY into sleep mode.
// - clearing sleep keeps configuration and resets state machines.
// - remote loop-out routes received data back to transmit.
module phyx_regs
  import phyx_pkg::*;
#(
  parameter int unsigned STATE_MACHINE_RESET_CYCLES = `PHYX_STATE_MACHINE_RESET_CYCLES
) (
  // clock, reset and freeze
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clk_en,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [11:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // phy core side
  input  wire phyx_status_t status_in,
  output phyx_ctrl_t        ctrl_out
);

  // elaboration check: the sequencer needs at least one cycle of pulse
  if (STATE_MACHINE_RESET_CYCLES < 1) begin : g_bad_cycles
    $error("phyx_regs: STATE_MACHINE_RESET_CYCLES must be at least 1");
  end

  // address phase capture
  logic        dp_write;
  logic [11:0] dp_addr;
  logic        addr_ok;

  assign addr_ok = hsel && hready && htrans[`PHYX_HTRANS_NONSEQ_BIT];

  // the data phase always completes in one cycle, so hreadyout stays high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= '0;
    end else if (clk_en) begin
      dp_write <= addr_ok && hwrite && (hsize == `PHYX_HSIZE_WORD);
      dp_addr  <= haddr;
    end
  end

  // read strobe at address phase so read data leaves a flip-flop in time
  logic rd_exp;
  logic rd_cfg;
  logic wr_cfg;

  assign rd_exp = addr_ok && !hwrite && (haddr == `PHYX_ADDR_EXPANSION);
  assign rd_cfg = addr_ok && !hwrite && (haddr == `PHYX_ADDR_VENDOR_CFG);
  assign wr_cfg = dp_write && (dp_addr == `PHYX_ADDR_VENDOR_CFG);

  // latched-high flags, one per bit; the event wins over the clearing read
  localparam int unsigned NFLAG = 2;
  logic             pd_fault;
  logic             page_rx;
  logic [NFLAG-1:0] flag_evt;
  logic [NFLAG-1:0] flag_q;

  assign flag_evt            = {status_in.pd_fault_evt, status_in.page_rx_evt};
  assign {pd_fault, page_rx} = flag_q;

  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_q[i] <= 1'b0;
      end else if (clk_en) begin
        if (flag_evt[i]) begin
          flag_q[i] <= 1'b1;
        end else if (rd_exp) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // expansion image; local next page and upper bits are constant zero
  logic [15:0] exp_image;

  always_comb begin
    exp_image                        = `PHYX_ZERO16;
    exp_image[`PHYX_EXP_PD_FAULT]    = pd_fault;
    exp_image[`PHYX_EXP_PARTNER_NP]  = status_in.partner_local_next_page_able;
    exp_image[`PHYX_EXP_LOCAL_NP]    = 1'b0;
    exp_image[`PHYX_EXP_PAGE_RX]     = page_rx;
    exp_image[`PHYX_EXP_PARTNER_AN]  = status_in.partner_an_able;
  end

  // vendor configuration storage; reserved read-only bits never store
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic        state_machine_reset_done;
  logic        state_machine_reset_busy;
  logic        state_machine_reset_start;
  logic        wake;

  assign wake = wr_cfg && cfg[`PHYX_CFG_SLEEP] && !hwdata[`PHYX_CFG_SLEEP];

  always_comb begin
    next_cfg = cfg;
    if (wr_cfg) begin
      next_cfg = hwdata[15:0] & `PHYX_CFG_WMASK;
    end
    // self-clear once the sequencer reports completion
    if (state_machine_reset_done && !(wr_cfg && hwdata[`PHYX_CFG_SM_RESET])) begin
      next_cfg[`PHYX_CFG_SM_RESET] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= `PHYX_CFG_RESET;
    end else if (clk_en) begin
      cfg <= next_cfg;
    end
  end

  // a fresh one-write or a wake from sleep starts the state machine reset
  assign state_machine_reset_start = (wr_cfg && hwdata[`PHYX_CFG_SM_RESET]) || wake;

  phyx_state_machine_reset_seq #(
    .CYCLES (STATE_MACHINE_RESET_CYCLES)
  ) u_state_machine_reset (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .start   (state_machine_reset_start),
    .busy    (state_machine_reset_busy),
    .done    (state_machine_reset_done)
  );

  // registered controls to the rest of the PHY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_out <= '0;
    end else if (clk_en) begin
      ctrl_out.link_100_good          <= next_cfg[`PHYX_CFG_FORCE_100] ||
                                         status_in.link_100_raw;
      ctrl_out.auto_reduced_power_en  <= next_cfg[`PHYX_CFG_RPD_EN];
      ctrl_out.mgmt_preamble_suppress <= next_cfg[`PHYX_CFG_PREAMBLE];
      ctrl_out.sleep_mode             <= next_cfg[`PHYX_CFG_SLEEP];
      ctrl_out.remote_loop_out        <= next_cfg[`PHYX_CFG_LOOP_OUT];
      // held from the start pulse through the whole count
      ctrl_out.state_machine_reset    <= state_machine_reset_start ||
                                         (state_machine_reset_busy && !state_machine_reset_done);
    end
  end

  // read data registered at the address phase; others read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `PHYX_ZERO32;
    end else if (clk_en) begin
      if (rd_exp) begin
        hrdata <= {16'h0000, exp_image};
      end else if (rd_cfg) begin
        hrdata <= {16'h0000, cfg};
      end else begin
        hrdata <= `PHYX_ZERO32;
      end
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// *** verif/phyx_regs_assertions.sv ***
// phyx_regs_assertions.sv: port checks of the expansion and config registers.
// assumes: bound to phyx_regs; one clock hclk, async active-low hresetn.
`timescale 1ns/1ns
module phyx_regs_assertions
  import phyx_pkg::*;
#(
  parameter int unsigned STATE_MACHINE_RESET_CYCLES = 4
) (
  // clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         clk_en,
  // ahb-lite
  input wire logic         hsel,
  input wire logic [11:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [2:0]   hsize,
  input wire logic [31:0]  hwdata,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  input wire logic         hreadyout,
  input wire logic         hresp,
  // phy core
  input wire phyx_status_t status_in,
  input wire phyx_ctrl_t   ctrl_out
);
  logic take;
  logic wr_cfg;
  logic rd_exp;
  assign take = hsel && hready && htrans[1] && clk_en;
  // mark which transfer is in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cfg <= 1'b0;
      rd_exp <= 1'b0;
    end else if (clk_en) begin
      wr_cfg <= take && hwrite && hsize == 3'h2 && haddr == 12'h040;
      rd_exp <= take && !hwrite && haddr == 12'h018;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_exp_rsvd_zero: assert property (rd_exp |-> hrdata[31:5] == 27'h0 && !hrdata[2])
    else $error("expansion reserved or local next page bit set");
  a_link_raw: assert property ($past(hresetn) && $past(status_in.link_100_raw)
    |-> ctrl_out.link_100_good) else $error("good link lost");
  a_link_force: assert property (wr_cfg && hwdata[7] |=> ctrl_out.link_100_good)
    else $error("forced link not reported");
  a_cfg_loop_sleep: assert property (wr_cfg |=>
    ctrl_out.remote_loop_out == $past(hwdata[0]) && ctrl_out.sleep_mode == $past(hwdata[1]))
    else $error("loop or sleep wrong");
  a_cfg_rpd_pre: assert property (wr_cfg |=>
    ctrl_out.mgmt_preamble_suppress == $past(hwdata[2])
    && ctrl_out.auto_reduced_power_en == $past(hwdata[4])) else $error("rpd or pre");
  a_ctrl_kept: assert property (!wr_cfg && $past(hresetn) |=>
    $stable({ctrl_out.sleep_mode, ctrl_out.mgmt_preamble_suppress,
    ctrl_out.auto_reduced_power_en})) else $error("config changed without a write");
  a_state_machine_reset_len: assert property ($rose(ctrl_out.state_machine_reset) |->
    ctrl_out.state_machine_reset[*5] ##1 !ctrl_out.state_machine_reset)
    else $error("reset pulse length wrong");
  a_state_machine_reset_cause: assert property ($rose(ctrl_out.state_machine_reset) |-> $past(wr_cfg))
    else $error("reset pulse without config write");
  // the slave never stalls and never signals an error
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error response seen");
  c_cfg_write: cover property (wr_cfg);
  c_state_machine_reset: cover property ($rose(ctrl_out.state_machine_reset));
  c_page_read: cover property (rd_exp && hrdata[1]);
endmodule
bind phyx_regs phyx_regs_assertions #(.STATE_MACHINE_RESET_CYCLES(STATE_MACHINE_RESET_CYCLES)) u_phyx_regs_assertions (
  .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .status_in, .ctrl_out);

// *** verif/phyx_mgmt_model.sv ***
// phyx_mgmt_model.sv: station management master on ahb-lite, single word transfers.
// assumes: the bank is the only slave; xfer is entered just after a rising edge.
`timescale 1ns/1ns
module phyx_mgmt_model (
  // clock
  input  wire logic        hclk,
  // ahb-lite master
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d; // released data must not look valid
  endtask
endmodule

// *** verif/testbench.sv ***
// testbench.sv: register sequences against phyx_regs through the management model.
// assumes: 20 MHz hclk; STATE_MACHINE_RESET_CYCLES set to 4, so the reset pulse spans 5 edges.
`timescale 1ns/1ns
module testbench
  import phyx_pkg::*;
;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         clk_en = 1'b1;
  logic         hsel, hwrite, hreadyout, hresp;
  logic [11:0]  haddr;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, rd;
  phyx_status_t st = '0;
  phyx_ctrl_t   ctrl;
  int           fail_count = 0;
  int           compares = 0;
  always #25 hclk = ~hclk;
  phyx_regs #(.STATE_MACHINE_RESET_CYCLES(4)) u_phyx_regs (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .status_in(st), .ctrl_out(ctrl));
  phyx_mgmt_model u_phyx_mgmt_model (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata);
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    u_phyx_mgmt_model.xfer(1'b0, a, 32'h0000_0000, rd);
    cmp32(rd, e);
  endtask
  // the extra ns lets the data phase edge update ctrl before it is looked at
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_phyx_mgmt_model.xfer(1'b1, a, d, rd);
    #1;
  endtask
  task automatic pulse(input logic pd, input logic pg);
    st.pd_fault_evt <= pd;
    st.page_rx_evt <= pg;
    @(posedge hclk);
    st.pd_fault_evt <= 1'b0;
    st.page_rx_evt <= 1'b0;
  endtask
  task automatic close_out;
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs about 60 cycles
  initial begin
    repeat (2000) @(posedge hclk);
    fail_count++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    cmp32({26'h0, ctrl}, 32'h0000_0010);
    rd_chk(12'h040, 32'h0000_0410);
    rd_chk(12'h018, 32'h0000_0000);
    st.partner_local_next_page_able <= 1'b1;
    st.partner_an_able <= 1'b1;
    pulse(1'b1, 1'b1);
    wr(12'h018, 32'h0000_0000);
    rd_chk(12'h018, 32'h0000_001B);
    rd_chk(12'h018, 32'h0000_0009);
    fork
      rd_chk(12'h018, 32'h0000_0009);
      pulse(1'b0, 1'b1);
    join
    rd_chk(12'h018, 32'h0000_000B);
    st.partner_local_next_page_able <= 1'b0;
    st.partner_an_able <= 1'b0;
    @(posedge hclk);
    rd_chk(12'h018, 32'h0000_0000);
    wr(12'h020, 32'hFFFF_FFFF);
    rd_chk(12'h020, 32'h0000_0000);
    wr(12'h040, 32'h0000_FFF7);
    cmp32({26'h0, ctrl}, 32'h0000_003E);
    rd_chk(12'h040, 32'h0000_FCF7);
    wr(12'h040, 32'h0000_0400);
    cmp32({26'h0, ctrl}, 32'h0000_0001);
    repeat (6) @(posedge hclk);
    #1;
    cmp32({26'h0, ctrl}, 32'h0000_0000);
    rd_chk(12'h040, 32'h0000_0400);
    wr(12'h040, 32'h0000_0408);
    cmp32({26'h0, ctrl}, 32'h0000_0001);
    rd_chk(12'h040, 32'h0000_0408);
    repeat (6) @(posedge hclk);
    rd_chk(12'h040, 32'h0000_0400);
    st.link_100_raw <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    cmp32({26'h0, ctrl}, 32'h0000_0020);
    // freeze: a line change must not reach the controls until enable returns
    @(posedge hclk);
    clk_en <= 1'b0;
    st.link_100_raw <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    cmp32({26'h0, ctrl}, 32'h0000_0020);
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    cmp32({26'h0, ctrl}, 32'h0000_0000);
    close_out;
  end
endmodule
